/* carrier_loop_pkg.sv */
// Shared constants and types of the carrier phase recovery loop
package carrier_loop_pkg;

  // ------------------------------------------------------------
  // Datapath widths
  // ------------------------------------------------------------
  localparam int DATA_W = 16;      // Soft symbol I or Q, signed
  localparam int GAIN_W = 5;       // Loop gain shift amounts
  localparam int ERR_W = 24;       // Phase error estimate
  localparam int INT_W = 24;       // Integral accumulator
  localparam int ERR_SH = 13;      // Scaling of the phase detector product
  localparam int UNIT_SH_MAX = 13; // Half point spacing is 2^(13 - mode)

  // ------------------------------------------------------------
  // Oscillator defaults (overridable per instance)
  // ------------------------------------------------------------
  localparam int LUT_AW_DEF = 8;   // Quarter table holds 2^8 words
  localparam int LUT_W_DEF = 16;
  localparam int ACC_W_DEF = 32;

  // ------------------------------------------------------------
  // Rates and timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SYM_RATE_MAX_KSPS = 6250;
  localparam int SYM_CYC_NOM = CLK_MHZ * 1000 / SYM_RATE_MAX_KSPS;
  localparam int MIN_STROBE_CYC = 12;
  localparam int PROC_CYC = 6;     // Strobe to output valid, empty queue
  localparam int FIFO_DEPTH = 8;

  // ------------------------------------------------------------
  // Modes and states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_QPSK = 2'h0,
    MOD_QAM16 = 2'h1,
    MOD_QAM64 = 2'h2,
    MOD_QAM256 = 2'h3
  } mod_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LUT = 6'h02,
    ST_ROT = 6'h04,
    ST_SLICE = 6'h08,
    ST_FILT = 6'h10,
    ST_NCO = 6'h20
  } loop_state_e;

  localparam logic [1:0] QUAD_COS = 2'h1; // Cosine leads sine by a quadrant

endpackage

/* carrier_loop.sv */
// Carrier phase recovery loop: input queue and symbol loop
// Operation
// - One symbol per strobe, hold otherwise
// - Selectable QPSK, 16, 64, 256-QAM slicing
// - Single clock, strobe carries symbol timing
// - Slicer picks nearest constellation point
// - Phase error is Im of y times conj(c)
// - PI filter with proportional and integral gains
// - Filter output drives oscillator frequency
// - Phase accumulator addresses sine/cosine table
// - Quarter table, mirroring and sign inversion
// - Table depth, widths are design parameters
// - Derotator multiplies input by oscillator output
// - Integral term visible at an output
// - New symbol taken from the queue at most once per six cycles
// - Clear input zeroes feedback state
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Symbol queue
// ------------------------------------------------------------
module sym_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic in_ready_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready_reg;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign in_ready = in_ready_reg;

  // Occupancy follows push and pop
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
  end

  // Ready is registered so the source sees a clean level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_reg <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready_reg <= (count_next < CW'(DEPTH));
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
    end
  end

  // Storage needs no reset, occupancy guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
endmodule // sym_fifo

// ------------------------------------------------------------
// Loop top
// ------------------------------------------------------------
module carrier_loop
  import carrier_loop_pkg::*;
#(
  parameter int LUT_AW = LUT_AW_DEF,
  parameter int LUT_W = LUT_W_DEF,
  parameter int ACC_W = ACC_W_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic init_clear,
  input wire logic [1:0] mod_sel,
  input wire logic [GAIN_W-1:0] kp_shift,
  input wire logic [GAIN_W-1:0] ki_shift,
  input wire logic sym_strobe,
  input wire logic signed [DATA_W-1:0] sym_i,
  input wire logic signed [DATA_W-1:0] sym_q,
  output logic sym_ready,
  output logic out_valid,
  output logic signed [DATA_W-1:0] out_i,
  output logic signed [DATA_W-1:0] out_q,
  output logic signed [DATA_W-1:0] dec_i,
  output logic signed [DATA_W-1:0] dec_q,
  output logic signed [INT_W-1:0] integ_out,
  output logic signed [INT_W:0] freq_out
);
  localparam int LUT_DEPTH = 1 << LUT_AW;
  localparam int LUT_AMP = (1 << (LUT_W - 1)) - 1;
  localparam int PD_W = 2 * DATA_W + 1;
  localparam logic signed [INT_W-1:0] INT_MAX = {1'b0, {(INT_W - 1){1'b1}}};
  localparam logic signed [INT_W-1:0] INT_MIN = {1'b1, {(INT_W - 1){1'b0}}};

  // ------------------------------------------------------------
  // Quarter sine table
  // ------------------------------------------------------------
  // Rational sine approximation, evaluated at elaboration, mid-bin
  function automatic int qsine(input int i, input int n, input int amp);
    longint u;
    longint p;
    u = 2 * i + 1;
    p = u * (4 * longint'(n) - u);
    return int'((longint'(amp) * 4 * p) / (20 * longint'(n) * n - p));
  endfunction

  logic signed [LUT_W-1:0] lut [LUT_DEPTH];

  // Only one quadrant is stored
  for (genvar g = 0; g < LUT_DEPTH; g++) begin : g_lut
    assign lut[g] = LUT_W'(qsine(g, LUT_DEPTH, LUT_AMP));
  end

  // Full wave from the quadrant by mirroring the address and the sign
  function automatic logic signed [LUT_W-1:0] wave(
    input logic [1:0] quad,
    input logic [LUT_AW-1:0] addr
  );
    logic [LUT_AW-1:0] ad;
    ad = quad[0] ? ~addr : addr;
    return quad[1] ? -lut[ad] : lut[ad];
  endfunction

  // ------------------------------------------------------------
  // Slicer
  // ------------------------------------------------------------
  // Nearest odd level on one axis, clamped to the outer ring
  function automatic logic signed [DATA_W-1:0] slice_axis(
    input logic signed [DATA_W-1:0] v,
    input logic [1:0] mode
  );
    logic [3:0] sh;
    logic signed [DATA_W-1:0] idx;
    logic signed [DATA_W-1:0] lim;
    sh = 4'(UNIT_SH_MAX) - {2'h0, mode};
    idx = v >>> (sh + 4'h1);
    lim = DATA_W'(1) << mode; // Half the levels per axis
    if (idx >= lim) begin
      idx = lim - DATA_W'(1);
    end
    if (idx < -lim) begin
      idx = -lim;
    end
    return ((idx <<< 1) + DATA_W'(1)) <<< sh;
  endfunction

  // ------------------------------------------------------------
  // Input queue
  // ------------------------------------------------------------
  loop_state_e state_reg;
  logic fifo_valid;
  logic [2*DATA_W-1:0] fifo_data;
  logic take;

  assign take = fifo_valid && (state_reg == ST_IDLE);

  // Absorbs strobes that arrive while a symbol is still in flight
  sym_fifo #(
    .WIDTH(2 * DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(sym_strobe),
    .in_data({sym_i, sym_q}),
    .in_ready(sym_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(take)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Six cycles per symbol, well inside the twelve cycle spacing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take) begin
            state_reg <= ST_LUT;
          end
        end
        ST_LUT: begin
          state_reg <= ST_ROT;
        end
        ST_ROT: begin
          state_reg <= ST_SLICE;
        end
        ST_SLICE: begin
          state_reg <= ST_FILT;
        end
        ST_FILT: begin
          state_reg <= ST_NCO;
        end
        ST_NCO: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Capture and derotation
  // ------------------------------------------------------------
  logic signed [DATA_W-1:0] xi_reg;
  logic signed [DATA_W-1:0] xq_reg;
  logic signed [LUT_W-1:0] cos_reg;
  logic signed [LUT_W-1:0] sin_reg;
  logic signed [DATA_W-1:0] yi_reg;
  logic signed [DATA_W-1:0] yq_reg;
  logic signed [ACC_W-1:0] phase_reg;
  logic signed [PD_W-1:0] rot_i;
  logic signed [PD_W-1:0] rot_q;
  logic [1:0] quad;
  logic [LUT_AW-1:0] addr;

  assign quad = phase_reg[ACC_W-1 -: 2];
  assign addr = phase_reg[ACC_W-3 -: LUT_AW];
  // Multiply by the conjugate phasor to undo the rotation
  // Operands widened first so no product is formed at its operands' width
  assign rot_i = PD_W'(xi_reg) * PD_W'(cos_reg) + PD_W'(xq_reg) * PD_W'(sin_reg);
  assign rot_q = PD_W'(xq_reg) * PD_W'(cos_reg) - PD_W'(xi_reg) * PD_W'(sin_reg);

  // Each stage loads only in its own state, else holds
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xi_reg <= '0;
      xq_reg <= '0;
      cos_reg <= '0;
      sin_reg <= '0;
      yi_reg <= '0;
      yq_reg <= '0;
    end else begin
      if (take) begin
        xi_reg <= fifo_data[2*DATA_W-1 -: DATA_W];
        xq_reg <= fifo_data[DATA_W-1:0];
      end
      if (state_reg == ST_LUT) begin
        sin_reg <= wave(quad, addr);
        cos_reg <= wave(quad + QUAD_COS, addr);
      end
      if (state_reg == ST_ROT) begin
        yi_reg <= DATA_W'(rot_i >>> (LUT_W - 1));
        yq_reg <= DATA_W'(rot_q >>> (LUT_W - 1));
      end
    end
  end

  // ------------------------------------------------------------
  // Decision and phase detector
  // ------------------------------------------------------------
  logic signed [DATA_W-1:0] di_reg;
  logic signed [DATA_W-1:0] dq_reg;
  logic signed [DATA_W-1:0] di_c;
  logic signed [DATA_W-1:0] dq_c;
  logic signed [PD_W-1:0] pd;
  logic signed [ERR_W-1:0] err_reg;

  assign di_c = slice_axis(yi_reg, mod_sel);
  assign dq_c = slice_axis(yq_reg, mod_sel);
  // Im{y * conj(c)} = yq*ci - yi*cq
  assign pd = PD_W'(yq_reg) * PD_W'(di_c) - PD_W'(yi_reg) * PD_W'(dq_c);

  // Error is part of the loop, so clear zeroes it too
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      di_reg <= '0;
      dq_reg <= '0;
      err_reg <= '0;
    end else begin
      if (state_reg == ST_SLICE) begin
        di_reg <= di_c;
        dq_reg <= dq_c;
      end
      if (init_clear) begin
        err_reg <= '0;
      end else if (state_reg == ST_SLICE) begin
        err_reg <= ERR_W'(pd >>> ERR_SH);
      end
    end
  end

  // ------------------------------------------------------------
  // PI loop filter
  // ------------------------------------------------------------
  logic signed [INT_W-1:0] integ_reg;
  logic signed [INT_W:0] integ_sum;
  logic signed [INT_W-1:0] integ_sat;
  logic signed [INT_W:0] freq_reg;

  assign integ_sum = (INT_W + 1)'(integ_reg) + (INT_W + 1)'(err_reg >>> ki_shift);

  // Saturate rather than wrap, a wrapped integral would flip the loop
  always_comb begin
    integ_sat = integ_sum[INT_W-1:0];
    if (integ_sum[INT_W] != integ_sum[INT_W-1]) begin
      integ_sat = integ_sum[INT_W] ? INT_MIN : INT_MAX;
    end
  end

  // Integral and frequency estimate update once per symbol
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      integ_reg <= '0;
      freq_reg <= '0;
    end else if (init_clear) begin
      integ_reg <= '0;
      freq_reg <= '0;
    end else if (state_reg == ST_FILT) begin
      integ_reg <= integ_sat;
      freq_reg <= (INT_W + 1)'(integ_sat) + (INT_W + 1)'(err_reg >>> kp_shift);
    end
  end

  // ------------------------------------------------------------
  // Oscillator phase accumulator
  // ------------------------------------------------------------
  // Modulo arithmetic wraps the phase through all four quadrants
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_reg <= '0;
    end else if (init_clear) begin
      phase_reg <= '0;
    end else if (state_reg == ST_NCO) begin
      phase_reg <= phase_reg + ACC_W'(freq_reg);
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic out_valid_reg;
  logic signed [DATA_W-1:0] out_i_reg;
  logic signed [DATA_W-1:0] out_q_reg;
  logic signed [DATA_W-1:0] dec_i_reg;
  logic signed [DATA_W-1:0] dec_q_reg;

  // Results stand until the next symbol; valid is a single pulse
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_reg <= 1'b0;
      out_i_reg <= '0;
      out_q_reg <= '0;
      dec_i_reg <= '0;
      dec_q_reg <= '0;
    end else begin
      out_valid_reg <= (state_reg == ST_NCO);
      if (state_reg == ST_NCO) begin
        out_i_reg <= yi_reg;
        out_q_reg <= yq_reg;
        dec_i_reg <= di_reg;
        dec_q_reg <= dq_reg;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_i = out_i_reg;
  assign out_q = out_q_reg;
  assign dec_i = dec_i_reg;
  assign dec_q = dec_q_reg;
  assign integ_out = integ_reg;
  assign freq_out = freq_reg;
endmodule // carrier_loop

`default_nettype wire

/* carrier_loop_assertions.sv */
// Port-level checks of the carrier loop top
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module carrier_loop_chk
  import carrier_loop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic init_clear,
  input wire logic [1:0] mod_sel,
  input wire logic [GAIN_W-1:0] kp_shift,
  input wire logic [GAIN_W-1:0] ki_shift,
  input wire logic sym_strobe,
  input wire logic signed [DATA_W-1:0] sym_i,
  input wire logic signed [DATA_W-1:0] sym_q,
  input wire logic sym_ready,
  input wire logic out_valid,
  input wire logic signed [DATA_W-1:0] out_i,
  input wire logic signed [DATA_W-1:0] out_q,
  input wire logic signed [DATA_W-1:0] dec_i,
  input wire logic signed [DATA_W-1:0] dec_q,
  input wire logic signed [INT_W-1:0] integ_out,
  input wire logic signed [INT_W:0] freq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Decision is an odd multiple of the half spacing of the mode
  function automatic bit lvl_ok(logic signed [DATA_W-1:0] v, logic [1:0] m);
    int u;
    u = 1 << (13 - m);
    return (int'(v) & (2 * u - 1)) == u;
  endfunction
  AST_VALID_GAP: assert property (out_valid |=> !out_valid [*5])
    else $error("output valid pulses closer than six cycles");
  AST_VALID_CAUSE: assert property ((sym_strobe && sym_ready) |-> ##[6:80] out_valid)
    else $error("accepted symbol gave no result");
  AST_OUT_HOLD: assert property (!out_valid |-> $stable(out_i) && $stable(out_q)
    && $stable(dec_i) && $stable(dec_q))
    else $error("outputs moved without a result");
  AST_CLEAR: assert property (init_clear |=> integ_out == 0 && freq_out == 0)
    else $error("clear left loop state nonzero");
  AST_INTEG_CAUSE: assert property ($changed(integ_out) && !$past(init_clear)
    |-> ##1 out_valid)
    else $error("integral moved outside a symbol update");
  AST_FREQ_CAUSE: assert property ($changed(freq_out) && !$past(init_clear)
    |-> ##1 out_valid)
    else $error("frequency moved outside a symbol update");
  AST_DEC_LEVEL: assert property (out_valid |-> lvl_ok(dec_i, mod_sel)
    && lvl_ok(dec_q, mod_sel))
    else $error("decision is not a point of the mode");
  AST_READY_BACK: assert property (!sym_ready |-> ##[1:8] sym_ready)
    else $error("queue stayed full too long");
endmodule // carrier_loop_chk

bind carrier_loop carrier_loop_chk chk (
  .clk(clk),
  .reset(reset),
  .init_clear(init_clear),
  .mod_sel(mod_sel),
  .kp_shift(kp_shift),
  .ki_shift(ki_shift),
  .sym_strobe(sym_strobe),
  .sym_i(sym_i),
  .sym_q(sym_q),
  .sym_ready(sym_ready),
  .out_valid(out_valid),
  .out_i(out_i),
  .out_q(out_q),
  .dec_i(dec_i),
  .dec_q(dec_q),
  .integ_out(integ_out),
  .freq_out(freq_out)
);
`default_nettype wire

/* tr_source.sv */
// Upstream timing recovery model: strobes with symbol data
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Strobe source
// ------------------------------------------------------------
module tr_source
  import carrier_loop_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [7:0] gap,
  input wire logic signed [DATA_W-1:0] val_i,
  input wire logic signed [DATA_W-1:0] val_q,
  output logic sym_strobe,
  output logic signed [DATA_W-1:0] sym_i,
  output logic signed [DATA_W-1:0] sym_q,
  output logic busy
);
  logic [7:0] left_reg;
  logic [7:0] wait_reg;
  logic [1:0] turn_reg;
  assign busy = left_reg != 8'h00;
  // Gap 0 jitters 12, 16, 20 cycles like a tracking timing loop
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      left_reg <= 8'h00;
      wait_reg <= 8'h00;
      turn_reg <= 2'h0;
      sym_strobe <= 1'b0;
      sym_i <= '0;
      sym_q <= '0;
    end else begin
      sym_strobe <= 1'b0;
      sym_i <= ~sym_i; // Stale data toggles so it never passes
      sym_q <= ~sym_q;
      if (start) begin
        left_reg <= count;
        wait_reg <= 8'h00;
      end else if (busy && wait_reg != 8'h00) begin
        wait_reg <= wait_reg - 8'h01;
      end else if (busy) begin
        sym_strobe <= 1'b1;
        sym_i <= val_i;
        sym_q <= val_q;
        left_reg <= left_reg - 8'h01;
        wait_reg <= (gap != 8'h00) ? gap - 8'h01 : 8'h0b + {4'h0, turn_reg, 2'h0};
        turn_reg <= (turn_reg == 2'h2) ? 2'h0 : turn_reg + 2'h1;
      end
    end
  end
endmodule // tr_source
`default_nettype wire

/* carrier_loop_tb_top.sv */
// Self-checking bench of the carrier loop
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %0d seen %0d", nm, e, g); end end
module carrier_loop_tb_top
  import carrier_loop_pkg::*;
;
  logic clk;
  logic reset = 1'b1;
  logic init_clear = 1'b0;
  logic [1:0] mod_sel = 2'h0;
  logic [GAIN_W-1:0] kp = 5'h1f;
  logic [GAIN_W-1:0] ki = 5'h1f;
  logic start = 1'b0;
  logic [7:0] count = 8'h00;
  logic [7:0] gap = 8'h00;
  logic signed [DATA_W-1:0] vi = '0;
  logic signed [DATA_W-1:0] vq = '0;
  logic strobe, ready, ov, busy;
  logic signed [DATA_W-1:0] si, sq, oi, oq, di, dq;
  logic signed [INT_W-1:0] integ;
  logic signed [INT_W:0] freq;
  int fails = 0;
  int checks = 0;
  int nout, nacc, nref;
  // ------------------------------------------------------------
  // Clock, partner, design, monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  tr_source src (.clk(clk), .reset(reset), .start(start), .count(count), .gap(gap),
    .val_i(vi), .val_q(vq), .sym_strobe(strobe), .sym_i(si), .sym_q(sq), .busy(busy));
  carrier_loop dut (.clk(clk), .reset(reset), .init_clear(init_clear), .mod_sel(mod_sel),
    .kp_shift(kp), .ki_shift(ki), .sym_strobe(strobe), .sym_i(si), .sym_q(sq),
    .sym_ready(ready), .out_valid(ov), .out_i(oi), .out_q(oq), .dec_i(di), .dec_q(dq),
    .integ_out(integ), .freq_out(freq));
  // Counts taken, refused and finished symbols
  always @(posedge clk) begin
    if (ov === 1'b1) nout++;
    if (strobe === 1'b1 && ready === 1'b1) nacc++;
    if (strobe === 1'b1 && ready === 1'b0) nref++;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic final_report;
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Nearest point of the mode, clamped to the outer ring
  function automatic logic signed [DATA_W-1:0] lvl(int v, int m);
    int u, mx, r;
    u = 1 << (13 - m);
    mx = ((2 << m) - 1) * u;
    r = ((v >>> (14 - m)) <<< (14 - m)) + u;
    if (r > mx) r = mx;
    if (r < -mx) r = -mx;
    return r[DATA_W-1:0];
  endfunction
  // Runs n strobes, then waits until every taken symbol came out
  task automatic send(input logic [7:0] n, input logic [7:0] g,
    input logic signed [DATA_W-1:0] a, input logic signed [DATA_W-1:0] b);
    int idle;
    idle = 0;
    @(negedge clk);
    nout = 0;
    nacc = 0;
    nref = 0;
    @(posedge clk);
    start <= 1'b1;
    count <= n;
    gap <= g;
    vi <= a;
    vq <= b;
    @(posedge clk);
    start <= 1'b0;
    for (int t = 0; t < 3000 && idle < 8; t++) begin
      @(posedge clk);
      idle = (busy === 1'b0 && nout == nacc) ? idle + 1 : 0;
    end
    if (idle < 8) begin
      fails++;
      final_report;
    end
    @(negedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("sym_ready", 1'b1, ready)
    `CHK("out_valid", 1'b0, ov)
    `CHK("integ_out", 0, integ)
    `CHK("dec_i", 0, di)
  endtask
  // Clear held, so phase stays zero and derotation is near identity
  task automatic t_slice;
    @(posedge clk);
    init_clear <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      mod_sel <= m[1:0];
      send(8'h01, 8'h0c, 16'sd5000, -16'sd20000);
      `CHK("dec_i", lvl(5000, m), di)
      `CHK("dec_q", lvl(-20000, m), dq)
      `CHK("out_i near", 1'b1, oi > 4900 && oi < 5100)
      `CHK("out_q near", 1'b1, oq > -20100 && oq < -19900)
      `CHK("freq_out", 0, freq)
    end
    @(posedge clk);
    init_clear <= 1'b0;
  endtask
  // Symbol behind its point: error negative, integral and sum follow
  task automatic t_loop;
    @(posedge clk);
    mod_sel <= 2'h0;
    kp <= 5'h02;
    ki <= 5'h04;
    send(8'h01, 8'h0c, 16'sd8192, 16'sd2000);
    `CHK("dec_q", 16'sd8192, dq)
    `CHK("integ sign", 1'b1, integ < 0)
    `CHK("freq vs integ", 1'b1, freq < integ)
    @(posedge clk);
    init_clear <= 1'b1;
    @(posedge clk);
    init_clear <= 1'b0;
    @(negedge clk);
    `CHK("integ cleared", 0, integ)
    `CHK("freq cleared", 0, freq)
  endtask
  task automatic t_jitter;
    @(posedge clk);
    mod_sel <= 2'h1;
    send(8'd20, 8'h00, 16'sd4096, -16'sd12288);
    `CHK("accepted", 20, nacc)
    `CHK("results", 20, nout)
    `CHK("dec_i", 16'sd4096, di)
    `CHK("dec_q", -16'sd12288, dq)
  endtask
  // Back to back strobes overrun the queue
  task automatic t_fill;
    @(posedge clk);
    mod_sel <= 2'h0;
    send(8'd14, 8'h01, 16'sd1000, -16'sd1000);
    `CHK("refused", 1'b1, nref > 0)
    `CHK("queue depth", 1'b1, nacc >= FIFO_DEPTH && nacc <= FIFO_DEPTH + 3)
    `CHK("results", nacc, nout)
    `CHK("dec_q", -16'sd8192, dq)
  endtask
  // ------------------------------------------------------------
  // Main sequence, with a second reset mid-run
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_slice;
    t_loop;
    t_jitter;
    t_fill;
    @(posedge clk);
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    final_report;
  end
endmodule // carrier_loop_tb_top
`default_nettype wire
